// >>> idl_defines.svh
// register offsets, field positions and reset values of the move unit
`ifndef IDL_DEFINES_SVH
`define IDL_DEFINES_SVH

// apb byte offsets
`define IDL_OFS_CMD      8'h00
`define IDL_OFS_WREG     8'h04
`define IDL_OFS_STATUS   8'h08
`define IDL_OFS_BANK     8'h0c
`define IDL_OFS_PCLATCH  8'h10
`define IDL_OFS_PTR0     8'h14
`define IDL_OFS_PTR1     8'h18
`define IDL_OFS_MEMADDR  8'h1c
`define IDL_OFS_MEMDATA  8'h20

// command word fields
`define IDL_CMD_OP_LSB   0
`define IDL_CMD_OP_W     3
`define IDL_CMD_PSEL     3
`define IDL_CMD_MODE_LSB 4
`define IDL_CMD_REL      6
`define IDL_CMD_K_LSB    8

// status bit positions
`define IDL_ST_ZERO      0
`define IDL_ST_DCARRY    1
`define IDL_ST_CARRY     2

// indirect window file addresses
`define IDL_WIN0_ADDR    7'h00
`define IDL_WIN1_ADDR    7'h01

// reset values
`define IDL_RST_BYTE     8'h00
`define IDL_RST_PTR      16'h0000
`define IDL_RST_BANK     5'h00
`define IDL_RST_PCLATCH  7'h00
`define IDL_RST_STATUS   3'h0
`define IDL_RST_WORD     32'h0000_0000
`define IDL_MEM_DEPTH    256

`endif

// >>> idl_pkg.sv
// types shared by the move unit
package idl_pkg;

   // operation codes of the command register
   typedef enum logic [2:0] {
      IDL_OP_NOP      = 3'h0,
      IDL_OP_INDLOAD  = 3'h1,
      IDL_OP_INDSTORE = 3'h2,
      IDL_OP_BANKLIT  = 3'h3,
      IDL_OP_PCLLIT   = 3'h4,
      IDL_OP_ACCLIT   = 3'h5,
      IDL_OP_ACCFILE  = 3'h6
   } idl_op_t;

   // pointer update mode encodings
   typedef enum logic [1:0] {
      IDL_PRE_INC  = 2'h0,
      IDL_PRE_DEC  = 2'h1,
      IDL_POST_INC = 2'h2,
      IDL_POST_DEC = 2'h3
   } idl_mode_t;

endpackage : idl_pkg

// >>> idl_ptr_unit.sv
// effective address and next value of one indirect pointer
`timescale 1ns/10ps
module idl_ptr_unit (
   input  wire logic              [15:0] ptrVal,
   input  wire idl_pkg::idl_mode_t       updMode,
   input  wire logic                     relMode,
   input  wire logic              [5:0]  offset,
   output logic                   [15:0] effAddr,
   output logic                   [15:0] ptrNxt
);
   logic [15:0] stepped;
   logic [15:0] relAddr;

   assign stepped = (updMode == idl_pkg::IDL_PRE_DEC ||
                     updMode == idl_pkg::IDL_POST_DEC)
                    ? ptrVal - 16'h0001 : ptrVal + 16'h0001;
   assign relAddr = ptrVal + {{10{offset[5]}}, offset};

   // choose address and pointer result per mode
   always_comb
   begin
      if (relMode)
      begin
         effAddr = relAddr;
         ptrNxt  = ptrVal;
      end
      else
      begin
         effAddr = (updMode == idl_pkg::IDL_PRE_INC ||
                    updMode == idl_pkg::IDL_PRE_DEC) ? stepped : ptrVal;
         ptrNxt  = stepped;
      end
   end
endmodule : idl_ptr_unit

// >>> idl_move_unit.sv
// move instruction unit with apb register access
// Overview of operation
// - indirect load reads pointed byte into accumulator; store writes it back
// - update mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
// - pre forms address pointer plus/minus one; relative adds -32..31
// - pointer ends stepped for inc/dec forms, unchanged for relative
// - window registers hold nothing; they reach memory at pointer
// - pointers wrap modulo 16 bits
// - pointer stepping leaves all status flags alone
// - bank literal load puts 5-bit value in bank select, no flags
// - latch literal load puts 7-bit value in pc high latch
// - accumulator literal load takes 8-bit value in one cycle
// - accumulator to file writes 7-bit addressed file register, no flags
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "idl_defines.svh"
module idl_move_unit (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [7:0]  accumulator,
   output logic      [4:0]  bank_select_reg,
   output logic      [6:0]  pc_high_latch
);
   logic [7:0]  mem [`IDL_MEM_DEPTH];
   logic [7:0]  accum_r;
   logic [2:0]  status_r;
   logic [4:0]  bank_r;
   logic [6:0]  pcl_r;
   logic [15:0] ptr0_r;
   logic [15:0] ptr1_r;
   logic [7:0]  memAddr_r;
   logic [31:0] cmd_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;

   logic               access;
   logic               wrAcc;
   logic               cmdGo;
   logic               mapped;
   logic [31:0]        rdMux;
   idl_pkg::idl_op_t   op;
   idl_pkg::idl_mode_t mode;
   logic               ptrSel;
   logic               relMode;
   logic [7:0]         lit;
   logic [6:0]         fileAddr;
   logic [15:0]        ea0;
   logic [15:0]        ea1;
   logic [15:0]        nx0;
   logic [15:0]        nx1;
   logic [15:0]        indAddr;
   logic [15:0]        fileTgt;
   logic [7:0]         loadByte;
   logic               indLoad;
   logic               indStore;
   logic               fileStore;
   logic               wrWreg;
   logic               wrStatus;
   logic               wrBank;
   logic               wrPcl;
   logic               wrPtr0;
   logic               wrPtr1;
   logic               wrMemAddr;
   logic               wrMemData;

   // bus decode; a transfer completes at the edge where pready is high
   assign access  = psel & penable & pready_r;
   assign wrAcc   = access & pwrite;
   assign cmdGo   = wrAcc & (paddr == `IDL_OFS_CMD);

   // command fields; literal ops ignore every other bit
   assign op       = idl_pkg::idl_op_t'(pwdata[`IDL_CMD_OP_LSB +:
                                              `IDL_CMD_OP_W]);
   assign mode     = idl_pkg::idl_mode_t'(pwdata[`IDL_CMD_MODE_LSB +: 2]);
   assign ptrSel   = pwdata[`IDL_CMD_PSEL];
   assign relMode  = pwdata[`IDL_CMD_REL];
   assign lit      = pwdata[`IDL_CMD_K_LSB +: 8];
   assign fileAddr = pwdata[`IDL_CMD_K_LSB +: 7];

   assign indLoad   = cmdGo & (op == idl_pkg::IDL_OP_INDLOAD);
   assign indStore  = cmdGo & (op == idl_pkg::IDL_OP_INDSTORE);
   assign fileStore = cmdGo & (op == idl_pkg::IDL_OP_ACCFILE);

   // register write strobes; one address per transfer, so a chain suffices
   always_comb
   begin
      wrWreg    = 1'b0;
      wrStatus  = 1'b0;
      wrBank    = 1'b0;
      wrPcl     = 1'b0;
      wrPtr0    = 1'b0;
      wrPtr1    = 1'b0;
      wrMemAddr = 1'b0;
      wrMemData = 1'b0;
      if (wrAcc)
      begin
         if (paddr == `IDL_OFS_WREG)
            wrWreg = 1'b1;
         else if (paddr == `IDL_OFS_STATUS)
            wrStatus = 1'b1;
         else if (paddr == `IDL_OFS_BANK)
            wrBank = 1'b1;
         else if (paddr == `IDL_OFS_PCLATCH)
            wrPcl = 1'b1;
         else if (paddr == `IDL_OFS_PTR0)
            wrPtr0 = 1'b1;
         else if (paddr == `IDL_OFS_PTR1)
            wrPtr1 = 1'b1;
         else if (paddr == `IDL_OFS_MEMADDR)
            wrMemAddr = 1'b1;
         else if (paddr == `IDL_OFS_MEMDATA)
            wrMemData = 1'b1;
      end
   end

   // one address unit per pointer
   idl_ptr_unit u_ptr0 (
      .ptrVal  (ptr0_r),
      .updMode (mode),
      .relMode (relMode),
      .offset  (pwdata[`IDL_CMD_K_LSB +: 6]),
      .effAddr (ea0),
      .ptrNxt  (nx0)
   );
   idl_ptr_unit u_ptr1 (
      .ptrVal  (ptr1_r),
      .updMode (mode),
      .relMode (relMode),
      .offset  (pwdata[`IDL_CMD_K_LSB +: 6]),
      .effAddr (ea1),
      .ptrNxt  (nx1)
   );

   assign indAddr  = ptrSel ? ea1 : ea0;
   // memory is smaller than the pointer span, so upper bits alias
   assign loadByte = mem[indAddr[7:0]];

   // window addresses redirect to the pointer target
   always_comb
   begin
      if (fileAddr == `IDL_WIN0_ADDR)
         fileTgt = ptr0_r;
      else if (fileAddr == `IDL_WIN1_ADDR)
         fileTgt = ptr1_r;
      else
         fileTgt = {4'h0, bank_r, fileAddr};
   end

   // data memory, written by stores and by the debug data register
   always_ff @(posedge ref_clk)
   begin
      if (indStore)
         mem[indAddr[7:0]] <= accum_r;
      else if (fileStore)
         mem[fileTgt[7:0]] <= accum_r;
      else if (wrMemData)
         mem[memAddr_r] <= pwdata[7:0];
   end

   // accumulator
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         accum_r <= `IDL_RST_BYTE;
      else if (indLoad)
         accum_r <= loadByte;
      else if (cmdGo && op == idl_pkg::IDL_OP_ACCLIT)
         accum_r <= lit;
      else if (wrWreg)
         accum_r <= pwdata[7:0];
   end

   // status flags; only the indirect load and a status register write touch zero
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         status_r <= `IDL_RST_STATUS;
      // zero set when loaded byte is zero
      else if (indLoad)
         status_r[`IDL_ST_ZERO] <= (loadByte == 8'h00);
      else if (wrStatus)
         status_r <= pwdata[2:0];
   end

   // bank select
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         bank_r <= `IDL_RST_BANK;
      else if (cmdGo && op == idl_pkg::IDL_OP_BANKLIT)
         bank_r <= lit[4:0];
      else if (wrBank)
         bank_r <= pwdata[4:0];
   end

   // pc high latch
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         pcl_r <= `IDL_RST_PCLATCH;
      else if (cmdGo && op == idl_pkg::IDL_OP_PCLLIT)
         pcl_r <= lit[6:0];
      else if (wrPcl)
         pcl_r <= pwdata[6:0];
   end

   // pointers; stepping here never reaches the status register
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ptr0_r <= `IDL_RST_PTR;
         ptr1_r <= `IDL_RST_PTR;
      end
      else if ((indLoad || indStore) && !ptrSel)
         ptr0_r <= nx0;
      else if (indLoad || indStore)
         ptr1_r <= nx1;
      else if (wrPtr0)
         ptr0_r <= pwdata[15:0];
      else if (wrPtr1)
         ptr1_r <= pwdata[15:0];
   end

   // debug memory address and last command
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         memAddr_r <= `IDL_RST_BYTE;
         cmd_r     <= `IDL_RST_WORD;
      end
      else if (wrMemAddr)
         memAddr_r <= pwdata[7:0];
      else if (cmdGo)
         cmd_r <= pwdata;
   end

   // read decode; unmapped addresses read zero with an error
   always_comb
   begin
      mapped = 1'b1;
      if (paddr == `IDL_OFS_CMD)
         rdMux = cmd_r;
      else if (paddr == `IDL_OFS_WREG)
         rdMux = {24'h0, accum_r};
      else if (paddr == `IDL_OFS_STATUS)
         rdMux = {29'h0, status_r};
      else if (paddr == `IDL_OFS_BANK)
         rdMux = {27'h0, bank_r};
      else if (paddr == `IDL_OFS_PCLATCH)
         rdMux = {25'h0, pcl_r};
      else if (paddr == `IDL_OFS_PTR0)
         rdMux = {16'h0, ptr0_r};
      else if (paddr == `IDL_OFS_PTR1)
         rdMux = {16'h0, ptr1_r};
      else if (paddr == `IDL_OFS_MEMADDR)
         rdMux = {24'h0, memAddr_r};
      else if (paddr == `IDL_OFS_MEMDATA)
         rdMux = {24'h0, mem[memAddr_r]};
      else
      begin
         rdMux  = 32'h0000_0000;
         mapped = 1'b0;
      end
   end

   // apb answer: registered in setup, so every access has one wait-free cycle
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= `IDL_RST_WORD;
      end
      else if (psel && !penable)
      begin
         pready_r  <= 1'b1;
         pslverr_r <= ~mapped;
         prdata_r  <= pwrite ? 32'h0000_0000 : rdMux;
      end
      else
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   assign prdata          = prdata_r;
   assign pready          = pready_r;
   assign pslverr         = pslverr_r;
   assign accumulator     = accum_r;
   assign bank_select_reg = bank_r;
   assign pc_high_latch   = pcl_r;
endmodule : idl_move_unit

// >>> idl_move_unit_sva.sv
// port checker for the move unit
`timescale 1ns/10ps
`include "idl_defines.svh"
module idl_move_unit_sva (
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [7:0]  accumulator,
   input wire logic [4:0]  bank_select_reg,
   input wire logic [6:0]  pc_high_latch
);
   // committing command transfer
   wire       cmdWr = psel && penable && pready && pwrite
                      && (paddr == `IDL_OFS_CMD);
   wire [2:0] op    = pwdata[2:0];
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // bus answers one cycle after setup
   AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_BANK_LIT: assert property (cmdWr && op == 3'h3 |=>
      bank_select_reg == $past(pwdata[12:8])) else $error("bank literal");
   AST_PCL_LIT: assert property (cmdWr && op == 3'h4 |=>
      pc_high_latch == $past(pwdata[14:8])) else $error("latch literal");
   AST_ACC_LIT: assert property (cmdWr && op == 3'h5 |=>
      accumulator == $past(pwdata[15:8])) else $error("acc literal");
   AST_ACC_KEEP: assert property (cmdWr &&
      (op == 3'h2 || op == 3'h6) |=> $stable(accumulator))
      else $error("store changed acc");
   AST_BANK_ONLY_WR: assert property ($changed(bank_select_reg) |->
      $past(psel && penable && pwrite)) else $error("bank moved");
   AST_PCL_ONLY_WR: assert property ($changed(pc_high_latch) |->
      $past(psel && penable && pwrite)) else $error("latch moved");
endmodule : idl_move_unit_sva

bind idl_move_unit idl_move_unit_sva idl_move_unit_sva_inst (.ref_clk,
   .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .accumulator, .bank_select_reg, .pc_high_latch);

// >>> testbench.sv
// self-checking bench for the move unit
`timescale 1ns/10ps
module testbench;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  accumulator;
   logic [4:0]  bank_select_reg;
   logic [6:0]  pc_high_latch;
   int          n_fail = 0;
   int          n_checks = 0;
   logic [32:0] expQ[$];
   logic [32:0] expNote;
   idl_move_unit idl_move_unit_inst (.ref_clk, .sys_rst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .accumulator,
      .bank_select_reg, .pc_high_latch);
   // free-running clock
   initial forever #5 ref_clk = ~ref_clk;
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   // one apb transfer, held until ready
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      if (i == 16)
      begin
         n_fail++;
         complete_run();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   // read notes its expectation before the bus sees it
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expQ.push_back({1'b0, e});
      xfer(1'b0, a, 32'h0);
   endtask : rd
   function automatic logic [31:0] cmd(input logic [2:0] o, input logic p,
      input logic [1:0] m, input logic r, input logic [7:0] k);
      return {16'h0, k, 1'b0, r, m, p, o};
   endfunction : cmd
   // monitor pairs each read answer with the oldest note
   always @(posedge ref_clk)
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         if (expQ.size() == 0) check(33'h0, 33'h1);
         else
         begin
            expNote = expQ.pop_front();
            check({pslverr, prdata}, expNote);
            // register ports must agree with what the bus reads back
            if (paddr == 8'h04) check(33'(accumulator), expNote);
            if (paddr == 8'h0c) check(33'(bank_select_reg), expNote);
            if (paddr == 8'h10) check(33'(pc_high_latch), expNote);
         end
      end
   // hang guard
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      complete_run();
   end
   initial
   begin
      logic [15:0] st, nx, ea;
      logic [7:0]  v, f, pa;
      int          m;
      void'($urandom(78));
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (m = 1; m < 7; m++) rd(8'(m * 4), 32'h0);
      // unmapped place answers with error
      expQ.push_back({1'b1, 32'h0});
      xfer(1'b0, 8'h24, 32'h0);
      v = 8'($urandom);
      wr(8'h00, cmd(3'h3, 1'b0, 2'h0, 1'b0, v));
      rd(8'h0c, 32'(v[4:0]));
      wr(8'h00, cmd(3'h4, 1'b0, 2'h0, 1'b0, v));
      rd(8'h10, 32'(v[6:0]));
      wr(8'h00, cmd(3'h5, 1'b0, 2'h0, 1'b0, v));
      rd(8'h04, 32'(v));
      rd(8'h08, 32'h0);
      // every update mode, started at the wrap edge
      for (m = 0; m < 4; m++)
      begin
         pa = $urandom_range(1) ? 8'h18 : 8'h14;
         st = m[0] ? 16'h0000 : 16'hffff;
         nx = m[0] ? st - 16'h1 : st + 16'h1;
         ea = m[1] ? st : nx;
         v = (m == 3) ? 8'h00 : 8'($urandom_range(255, 1));
         wr(pa, 32'(st));
         // carry flags preset so a stray clear is seen
         wr(8'h08, 32'h6);
         wr(8'h00, cmd(3'h5, 1'b0, 2'h0, 1'b0, v));
         // bit 3 of the pointer offset tells the two pointers apart
         wr(8'h00, cmd(3'h2, pa[3], m[1:0], 1'b0, 8'h00));
         rd(pa, 32'(nx));
         rd(8'h08, 32'h6);
         wr(8'h1c, 32'(ea[7:0]));
         rd(8'h20, 32'(v));
         wr(8'h00, cmd(3'h5, 1'b0, 2'h0, 1'b0, ~v));
         wr(8'h00, cmd(3'h1, pa[3], 2'h0, 1'b1, {2'b0, 6'(ea - nx)}));
         rd(8'h04, 32'(v));
         rd(pa, 32'(nx));
         rd(8'h08, {29'h0, 2'b11, v == 8'h00});
      end
      // most negative offset reaches below zero
      wr(8'h18, 32'h0010);
      wr(8'h00, cmd(3'h5, 1'b0, 2'h0, 1'b0, 8'h3c));
      wr(8'h00, cmd(3'h2, 1'b1, 2'h0, 1'b1, 8'h20));
      wr(8'h1c, 32'hf0);
      rd(8'h20, 32'h3c);
      rd(8'h18, 32'h0010);
      wr(8'h0c, 32'h0);
      f = 8'($urandom_range(127, 2));
      wr(8'h00, cmd(3'h6, 1'b0, 2'h0, 1'b0, f));
      wr(8'h1c, 32'(f));
      rd(8'h20, 32'h3c);
      rd(8'h08, 32'h7);
      // file one is a window onto the second pointer
      wr(8'h00, cmd(3'h5, 1'b0, 2'h0, 1'b0, 8'ha5));
      wr(8'h00, cmd(3'h6, 1'b0, 2'h0, 1'b0, 8'h01));
      wr(8'h1c, 32'h10);
      rd(8'h20, 32'ha5);
      repeat (3) @(posedge ref_clk);
      complete_run();
   end
endmodule : testbench
